// ### pkg/mss_pkg.sv
// package for the multichannel scan sequencer: widths, limits, states
// assumes one 40 MHz clock and a synchronous active-low reset
`default_nettype none
package mss_pkg;
  localparam int SCAN_W     = 24;
  localparam int SAMP_W     = 16;
  localparam int TOTAL_W    = 24;
  localparam int CHAN_W     = 7;
  localparam int GAIN_W     = 2;
  localparam int LIST_DEPTH = 8;
  localparam int LIST_AW    = 3;
  localparam int LEN_W      = 4;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = DATA_W + CHAN_W;
  localparam logic [SCAN_W-1:0]  SCAN_ONE  = 24'h000001;
  localparam logic [SAMP_W-1:0]  SAMP_ONE  = 16'h0001;
  localparam logic [TOTAL_W-1:0] TOTAL_ONE = 24'h000001;
  localparam logic [CHAN_W-1:0]  CHAN_ZERO = 7'h00;
  localparam logic [CHAN_W-1:0]  CHAN_ONE  = 7'h01;
  localparam logic [LIST_AW-1:0] IDX_ZERO  = 3'h0;
  localparam logic [LIST_AW-1:0] IDX_ONE   = 3'h1;
  localparam logic [LEN_W-1:0]   LEN_ONE   = 4'h1;
  typedef enum logic [1:0] {
    MSS_IDLE,
    MSS_WAIT,
    MSS_CONV,
    MSS_BUSY
  } mss_state_e;
endpackage
`default_nettype wire

// ### src/mss_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock; a word moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
module mss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;
  // flags are registered so valid and ready leave the fifo from flops
  logic             full_r, full_nxt, nempty_r, nempty_nxt;

  always_comb begin
    push       = in_valid_i && !full_r;
    pop        = out_ready_i && nempty_r;
    wr_nxt     = push ? wr_r + 1'b1 : wr_r;
    rd_nxt     = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt    = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    full_nxt   = (cnt_nxt == (AW+1)'(DEPTH));
    nempty_nxt = (cnt_nxt != '0);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      full_r   <= 1'b0;
      nempty_r <= 1'b0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      full_r   <= full_nxt;
      nempty_r <= nempty_nxt;
    end
  end

  // storage carries no reset, which keeps it mappable to ram
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  assign in_ready_o  = !full_r;
  assign out_valid_o = nempty_r;
  assign out_data_o  = mem_r[rd_r];
endmodule
`default_nettype wire

// ### src/mss_sequencer.sv
// scan sequencer: paces conversions, walks channels, buffers results
// assumes pacing_a ticks and converter handshakes synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - a new scan starts each time the scan interval counter expires with no scan in progress
// - conversions in a scan are spaced by the sample interval count
// - simultaneous mode converts every channel at once, no sample spacing
// - contiguous mode converts channels zero up to highest, every scan
// - list mode applies each entry's gain with its channel, in the same cycle as the strobe
// - single buffer mode stops after exactly scan total scans
// - double buffer mode runs on, wrapping every scan total scans
module mss_sequencer (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           start_i,
  input  wire logic                           abort_i,
  input  wire logic                           pacing_a_ext_i,
  input  wire logic                           ext_tick_i,
  input  wire logic                           list_mode_i,
  input  wire logic                           simultaneous_i,
  input  wire logic                           double_buffer_i,
  input  wire logic [mss_pkg::SCAN_W-1:0]     scan_interval_count_i,
  input  wire logic [mss_pkg::SAMP_W-1:0]     sample_interval_count_i,
  input  wire logic [mss_pkg::TOTAL_W-1:0]    scan_total_i,
  input  wire logic [mss_pkg::CHAN_W-1:0]     highest_channel_i,
  input  wire logic [mss_pkg::LEN_W-1:0]      channel_list_length_i,
  input  wire logic                           list_wr_i,
  input  wire logic [mss_pkg::LIST_AW-1:0]    list_wr_addr_i,
  input  wire logic [mss_pkg::CHAN_W-1:0]     list_wr_chan_i,
  input  wire logic [mss_pkg::GAIN_W-1:0]     list_wr_gain_i,
  output logic                                conv_start_o,
  output logic                                conv_all_o,
  output logic [mss_pkg::CHAN_W-1:0]          mux_channel_o,
  output logic [mss_pkg::GAIN_W-1:0]          gain_o,
  input  wire logic                           conv_done_i,
  input  wire logic [mss_pkg::DATA_W-1:0]     conv_data_i,
  output logic [mss_pkg::FIFO_W-1:0]          out_data_o,
  output logic                                out_valid_o,
  input  wire logic                           out_ready_i,
  output logic                                running_o,
  output logic                                done_o,
  output logic                                half_buffer_o,
  output logic                                overspeed_o,
  output logic                                overrun_o
);
  logic [mss_pkg::CHAN_W-1:0] list_chan_r [mss_pkg::LIST_DEPTH];
  logic [mss_pkg::GAIN_W-1:0] list_gain_r [mss_pkg::LIST_DEPTH];

  mss_pkg::mss_state_e            st_r, st_nxt;
  logic [mss_pkg::SCAN_W-1:0]     scan_cnt_r, scan_cnt_nxt;
  logic [mss_pkg::SAMP_W-1:0]     samp_cnt_r, samp_cnt_nxt;
  logic [mss_pkg::TOTAL_W-1:0]    scans_left_r, scans_left_nxt;
  logic [mss_pkg::TOTAL_W-1:0]    buf_pos_r, buf_pos_nxt;
  logic [mss_pkg::CHAN_W-1:0]     chan_r, chan_nxt;
  logic [mss_pkg::LIST_AW-1:0]    idx_r, idx_nxt;
  logic                           in_scan_r, in_scan_nxt;
  logic                           pend_r, pend_nxt;
  logic                           conv_start_r, conv_start_nxt;
  logic                           conv_all_r, conv_all_nxt;
  logic [mss_pkg::CHAN_W-1:0]     mux_r, mux_nxt;
  logic [mss_pkg::GAIN_W-1:0]     gain_r, gain_nxt;
  logic                           run_r, run_nxt;
  logic                           done_r, done_nxt;
  logic                           half_r, half_nxt;
  logic                           ovs_r, ovs_nxt;
  logic                           ovr_r, ovr_nxt;
  logic                           tick, scan_start, last_conv, scan_end;
  logic [mss_pkg::FIFO_W-1:0]     fifo_in;
  logic                           fifo_ready;
  logic [mss_pkg::TOTAL_W-1:0]    half_mark;

  always_ff @(posedge clk_i) begin
    if (list_wr_i) begin
      list_chan_r[list_wr_addr_i] <= list_wr_chan_i;
      list_gain_r[list_wr_addr_i] <= list_wr_gain_i;
    end
  end

  always_comb begin
    // internal pacing_a ticks every clock
    tick       = pacing_a_ext_i ? ext_tick_i : 1'b1;
    // scan counter runs free while active; reload on expiry avoids drift
    scan_start = run_r && tick && (scan_cnt_r == mss_pkg::SCAN_ONE);
    last_conv  = simultaneous_i ? 1'b1
               : list_mode_i
                 ? ({1'b0, idx_r} + mss_pkg::LEN_ONE
                    == channel_list_length_i)
                 : (chan_r == highest_channel_i);
    scan_end   = conv_done_i && !pend_r && in_scan_r;
    half_mark  = scan_total_i >> 1;
    fifo_in    = {mux_r, conv_data_i};
  end

  always_comb begin
    st_nxt         = st_r;
    scan_cnt_nxt   = scan_cnt_r;
    samp_cnt_nxt   = samp_cnt_r;
    scans_left_nxt = scans_left_r;
    buf_pos_nxt    = buf_pos_r;
    chan_nxt       = chan_r;
    idx_nxt        = idx_r;
    in_scan_nxt    = in_scan_r;
    pend_nxt       = pend_r;
    conv_start_nxt = 1'b0;
    conv_all_nxt   = conv_all_r;
    mux_nxt        = mux_r;
    gain_nxt       = gain_r;
    run_nxt        = run_r;
    done_nxt       = done_r;
    half_nxt       = 1'b0;
    ovs_nxt        = ovs_r;
    ovr_nxt        = ovr_r;
    if (run_r && tick) begin
      scan_cnt_nxt = (scan_cnt_r == mss_pkg::SCAN_ONE)
                   ? scan_interval_count_i
                   : scan_cnt_r - mss_pkg::SCAN_ONE;
      if (samp_cnt_r != mss_pkg::SAMP_ONE) begin
        samp_cnt_nxt = samp_cnt_r - mss_pkg::SAMP_ONE;
      end
    end
    case (st_r)
      mss_pkg::MSS_IDLE: begin
        if (start_i) begin
          run_nxt        = 1'b1;
          done_nxt       = 1'b0;
          ovs_nxt        = 1'b0;
          ovr_nxt        = 1'b0;
          scan_cnt_nxt   = mss_pkg::SCAN_ONE;
          scans_left_nxt = scan_total_i;
          buf_pos_nxt    = '0;
          st_nxt         = mss_pkg::MSS_WAIT;
        end
      end
      mss_pkg::MSS_WAIT: begin
        if (scan_start) begin
          chan_nxt     = mss_pkg::CHAN_ZERO;
          idx_nxt      = mss_pkg::IDX_ZERO;
          samp_cnt_nxt = mss_pkg::SAMP_ONE;
          in_scan_nxt  = 1'b1;
          st_nxt       = mss_pkg::MSS_CONV;
        end
      end
      mss_pkg::MSS_CONV: begin
        if (samp_cnt_r == mss_pkg::SAMP_ONE && (tick || simultaneous_i)) begin
          conv_start_nxt = 1'b1;
          conv_all_nxt   = simultaneous_i;
          // list entry gain set with the channel, in the same cycle as the strobe
          mux_nxt  = list_mode_i ? list_chan_r[idx_r] : chan_r;
          gain_nxt = list_mode_i ? list_gain_r[idx_r] : '0;
          samp_cnt_nxt = sample_interval_count_i;
          pend_nxt     = !last_conv;
          chan_nxt     = chan_r + mss_pkg::CHAN_ONE;
          idx_nxt      = idx_r + mss_pkg::IDX_ONE;
          st_nxt       = mss_pkg::MSS_BUSY;
        end
      end
      mss_pkg::MSS_BUSY: begin
        if (conv_done_i) begin
          st_nxt = pend_r ? mss_pkg::MSS_CONV : mss_pkg::MSS_WAIT;
        end
      end
      default: st_nxt = mss_pkg::MSS_IDLE;
    endcase
    if (scan_start && st_r != mss_pkg::MSS_WAIT
        && st_r != mss_pkg::MSS_IDLE) begin
      ovs_nxt = 1'b1;
    end
    if (scan_end) begin
      in_scan_nxt = 1'b0;
      if (double_buffer_i) begin
        buf_pos_nxt = (buf_pos_r + mss_pkg::TOTAL_ONE == scan_total_i)
                    ? '0 : buf_pos_r + mss_pkg::TOTAL_ONE;
        half_nxt = (buf_pos_r + mss_pkg::TOTAL_ONE == half_mark)
                || (buf_pos_r + mss_pkg::TOTAL_ONE == scan_total_i);
      end else begin
        scans_left_nxt = scans_left_r - mss_pkg::TOTAL_ONE;
        if (scans_left_r == mss_pkg::TOTAL_ONE) begin
          run_nxt  = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = mss_pkg::MSS_IDLE;
        end
      end
    end
    // after the start clear, so a word lost at the start edge still sets it
    if (conv_done_i && !fifo_ready) begin
      // a full fifo loses the sample: flag it rather than stall the adc
      ovr_nxt = 1'b1;
    end
    if (abort_i) begin
      run_nxt     = 1'b0;
      in_scan_nxt = 1'b0;
      pend_nxt    = 1'b0;
      st_nxt      = mss_pkg::MSS_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r         <= mss_pkg::MSS_IDLE;
      scan_cnt_r   <= mss_pkg::SCAN_ONE;
      samp_cnt_r   <= mss_pkg::SAMP_ONE;
      scans_left_r <= '0;
      buf_pos_r    <= '0;
      chan_r       <= '0;
      idx_r        <= '0;
      in_scan_r    <= 1'b0;
      pend_r       <= 1'b0;
      conv_start_r <= 1'b0;
      conv_all_r   <= 1'b0;
      mux_r        <= '0;
      gain_r       <= '0;
      run_r        <= 1'b0;
      done_r       <= 1'b0;
      half_r       <= 1'b0;
      ovs_r        <= 1'b0;
      ovr_r        <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      scan_cnt_r   <= scan_cnt_nxt;
      samp_cnt_r   <= samp_cnt_nxt;
      scans_left_r <= scans_left_nxt;
      buf_pos_r    <= buf_pos_nxt;
      chan_r       <= chan_nxt;
      idx_r        <= idx_nxt;
      in_scan_r    <= in_scan_nxt;
      pend_r       <= pend_nxt;
      conv_start_r <= conv_start_nxt;
      conv_all_r   <= conv_all_nxt;
      mux_r        <= mux_nxt;
      gain_r       <= gain_nxt;
      run_r        <= run_nxt;
      done_r       <= done_nxt;
      half_r       <= half_nxt;
      ovs_r        <= ovs_nxt;
      ovr_r        <= ovr_nxt;
    end
  end

  mss_fifo #(
    .WIDTH (mss_pkg::FIFO_W),
    .DEPTH (mss_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (fifo_in),
    .in_valid_i  (conv_done_i),
    .in_ready_o  (fifo_ready),
    .out_data_o  (out_data_o),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i)
  );

  assign conv_start_o  = conv_start_r;
  assign conv_all_o    = conv_all_r;
  assign mux_channel_o = mux_r;
  assign gain_o        = gain_r;
  assign running_o     = run_r;
  assign done_o        = done_r;
  assign half_buffer_o = half_r;
  assign overspeed_o   = ovs_r;
  assign overrun_o     = ovr_r;
endmodule
`default_nettype wire

// ### tb/mss_adc_model.sv
// converter and input mux model: one answer per strobe after lat_i
// assumes strobes never overlap a pending conversion
`timescale 1ns/1ps
`default_nettype none
module mss_adc_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        conv_start_i,
  input  wire logic [6:0]  chan_i,
  input  wire logic [1:0]  gain_i,
  input  wire logic [3:0]  lat_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  int cnt;
  // data toggles outside a done pulse so stale values never match
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (!rst_b_i) begin
      cnt    <= 0;
      data_o <= 16'h0000;
    end else if (conv_start_i) begin
      cnt <= lat_i + 1;
    end else if (cnt == 1) begin
      cnt    <= 0;
      done_o <= 1'b1;
      data_o <= {7'h00, gain_i, chan_i};
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/mss_sequencer_properties.sv
// checker for the scan sequencer: pacing, channel order, flags
// assumes it is bound to the sequencer, clk_i domain only
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_properties (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        start_i,
  input wire logic        abort_i,
  input wire logic        pacing_a_ext_i,
  input wire logic        list_mode_i,
  input wire logic        simultaneous_i,
  input wire logic        double_buffer_i,
  input wire logic [23:0] scan_interval_count_i,
  input wire logic [15:0] sample_interval_count_i,
  input wire logic [6:0]  highest_channel_i,
  input wire logic        conv_start_o,
  input wire logic        conv_all_o,
  input wire logic [6:0]  mux_channel_o,
  input wire logic [1:0]  gain_o,
  input wire logic        running_o,
  input wire logic        done_o,
  input wire logic        half_buffer_o,
  input wire logic        overspeed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic        contig;
  logic        seen_r, seen_nxt;
  logic [23:0] gap_r, gap_nxt;
  logic [15:0] samp_r, samp_nxt;
  logic [6:0]  prev_r, prev_nxt;
  assign contig = !list_mode_i && !simultaneous_i;
  // gap counts cycles since the last channel 0 strobe, samp since any
  always_comb begin
    gap_nxt  = gap_r + 24'h000001;
    samp_nxt = samp_r + 16'h0001;
    prev_nxt = prev_r;
    seen_nxt = seen_r;
    if (conv_start_o) begin
      samp_nxt = 16'h0001;
      prev_nxt = mux_channel_o;
    end
    if (conv_start_o && mux_channel_o == 7'h00) begin
      gap_nxt  = 24'h000001;
      seen_nxt = 1'b1;
    end
    // first scan of a run has no predecessor to measure against
    if ((start_i && !running_o) || !rst_b_i) begin
      seen_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    {seen_r, gap_r, samp_r, prev_r} <= {seen_nxt, gap_nxt, samp_nxt, prev_nxt};
  end
  a_scan_pacing: assert property (conv_start_o && contig &&
    seen_r && mux_channel_o == 7'h00 && !pacing_a_ext_i && !overspeed_o
    |-> gap_r == scan_interval_count_i) else $error("scan spacing wrong");
  a_samp_pacing: assert property (conv_start_o && contig &&
    !pacing_a_ext_i && mux_channel_o != 7'h00
    |-> samp_r == sample_interval_count_i) else $error("sample spacing");
  a_chan_ascend: assert property (conv_start_o && contig &&
    mux_channel_o != 7'h00 |-> mux_channel_o == prev_r + 7'h01)
    else $error("channel not ascending");
  a_chan_top: assert property (conv_start_o && contig
    |-> mux_channel_o <= highest_channel_i) else $error("channel too high");
  a_contig_gain: assert property (conv_start_o && !list_mode_i
    |-> gain_o == 2'h0) else $error("gain set in contiguous mode");
  a_sim_all: assert property (conv_start_o && simultaneous_i
    |-> conv_all_o) else $error("simultaneous strobe missing");
  a_first_conv: assert property (start_i && !running_o &&
    !abort_i && !pacing_a_ext_i |-> ##3 conv_start_o)
    else $error("first strobe late");
  a_done_stops: assert property ($rose(done_o)
    |-> !running_o ##1 !conv_start_o [*8]) else $error("run after done");
  a_half_dbl: assert property (half_buffer_o
    |-> double_buffer_i && running_o) else $error("half flag misplaced");
  a_ovs_sticky: assert property (overspeed_o && !start_i
    |=> overspeed_o) else $error("overspeed lost");
  c_done: cover property ($rose(done_o));
  c_half: cover property (half_buffer_o);
  c_ovs: cover property ($rose(overspeed_o));
endmodule
`default_nettype wire

// ### tb/mss_sequencer_tb_top.sv
// testbench top: random and corner acquisitions through the sequencer
// assumes the converter model answers well inside one sample interval
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_tb_top;
  logic        clk_i = 0, rst_b_i = 0, start_i = 0, abort_i = 0;
  logic        pacing_a_ext_i = 0, ext_tick_i = 0, list_mode_i = 0;
  logic        simultaneous_i = 0, double_buffer_i = 0, list_wr_i = 0;
  logic        out_ready_i = 0, conv_done_i, sink_en = 1;
  logic [23:0] scan_interval_count_i = 0, scan_total_i = 0;
  logic [15:0] sample_interval_count_i = 0, conv_data_i;
  logic [6:0]  highest_channel_i = 0, list_wr_chan_i = 0, mux_channel_o;
  logic [3:0]  channel_list_length_i = 1, lat = 1;
  logic [2:0]  list_wr_addr_i = 0;
  logic [1:0]  list_wr_gain_i = 0, gain_o;
  logic [22:0] out_data_o;
  logic        conv_start_o, conv_all_o, out_valid_o, running_o, done_o;
  logic        half_buffer_o, overspeed_o, overrun_o;
  logic [8:0]  lst [8];
  logic [22:0] got [$];
  int          mismatches = 0, samples_checked = 0, hb = 0, tk = 0;
  mss_sequencer DUT (.*);
  mss_adc_model u_adc (.clk_i, .rst_b_i, .conv_start_i(conv_start_o),
    .chan_i(mux_channel_o), .gain_i(gain_o), .lat_i(lat),
    .done_o(conv_done_i), .data_o(conv_data_i));
  always #12.5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    tk <= tk + 1;
    ext_tick_i <= (tk % 3 == 0);
    out_ready_i <= sink_en & ($urandom_range(3) != 0);
  end
  always @(posedge clk_i) begin
    if (out_valid_o && out_ready_i) got.push_back(out_data_o);
    if (half_buffer_o) hb++;
  end
  function automatic logic [22:0] word(input int k);
    logic [8:0] e;
    e = list_mode_i ? lst[k % channel_list_length_i]
                    : {2'h0, 7'(k % (highest_channel_i + 1))};
    return {e[6:0], 7'h00, e};
  endfunction
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // second start mid-run must be ignored; word counts expose it
  task automatic go(input int wait_c);
    got.delete();
    hb = 0;
    @(negedge clk_i) start_i = 1;
    @(negedge clk_i) start_i = 0;
    repeat (60) @(negedge clk_i);
    start_i = 1;
    @(negedge clk_i) start_i = 0;
    for (int i = 0; i < wait_c && done_o !== 1'b1; i++) @(negedge clk_i);
    repeat (40) @(negedge clk_i);
  endtask
  initial begin
    #(80000 * 25);
    mismatches++;
    results();
  end
  initial begin
    int n, pre_n;
    void'($urandom(32'h779CFC85));
    repeat (4) @(negedge clk_i);
    chk(running_o === 1'b0 && out_valid_o === 1'b0 && done_o === 1'b0,
        "reset");
    rst_b_i = 1;
    for (int a = 0; a < 8; a++) begin
      lst[a] = 9'($urandom_range(511)) & 9'h187;
      @(negedge clk_i);
      list_wr_i = 1;
      list_wr_addr_i = 3'(a);
      {list_wr_gain_i, list_wr_chan_i} = {lst[a][8:7], lst[a][6:0]};
    end
    @(negedge clk_i) list_wr_i = 0;
    // 0-2 contiguous, 3-4 list of 8 and 1, 5 simultaneous, 6 external
    for (int m = 0; m < 7; m++) begin
      lat = 4'(1 + $urandom_range(13));
      highest_channel_i = 7'($urandom_range(3));
      list_mode_i = (m == 3 || m == 4);
      simultaneous_i = (m == 5);
      pacing_a_ext_i = (m == 6);
      channel_list_length_i = (m == 3) ? 4'h8 : 4'h1;
      sample_interval_count_i = (m == 6) ? 16'h0008
                              : 16'(100 + $urandom_range(19));
      pre_n = 1 + $urandom_range(1);
      // equal pre and post trigger counts keep the total even
      scan_total_i = 24'(pre_n + pre_n);
      n = list_mode_i ? channel_list_length_i : highest_channel_i + 1;
      scan_interval_count_i = 24'(n * sample_interval_count_i
                                  + 20 + $urandom_range(40));
      go(20000);
      n = simultaneous_i ? 1 : n;
      chk(got.size() == n * scan_total_i, "word count");
      if (!simultaneous_i)
        foreach (got[k]) chk(got[k] === word(k), "word");
      chk(done_o === 1'b1 && running_o === 1'b0, "completion");
    end
    {list_mode_i, simultaneous_i, pacing_a_ext_i} = 3'h0;
    highest_channel_i = 7'h03;
    sample_interval_count_i = 16'h0064;
    scan_interval_count_i = 24'h000096;
    go(20000);
    chk(overspeed_o === 1'b1 && done_o === 1'b1, "overspeed");
    highest_channel_i = 7'h00;
    double_buffer_i = 1;
    scan_interval_count_i = 24'h000078;
    scan_total_i = 24'h000004;
    go(950);
    chk(hb == 4 && running_o === 1'b1, "circular");
    @(negedge clk_i) abort_i = 1;
    @(negedge clk_i) abort_i = 0;
    repeat (3) @(negedge clk_i);
    chk(running_o === 1'b0 && done_o === 1'b0, "abort");
    double_buffer_i = 0;
    // stalled sink: fifo fills, then must hand out exactly its depth
    sink_en = 0;
    highest_channel_i = 7'h07;
    scan_interval_count_i = 24'h000334;
    go(20000);
    chk(overrun_o === 1'b1, "overrun");
    sink_en = 1;
    repeat (80) @(negedge clk_i);
    chk(got.size() == 16, "fifo depth");
    results();
  end
endmodule
bind mss_sequencer mss_sequencer_properties u_chk (.*);
`default_nettype wire
